// ==== common/ibs_map.svh ====
`ifndef IBS_MAP_SVH
`define IBS_MAP_SVH

// ----------------------------------------
// Clock and timing
// ----------------------------------------
`define IBS_CLK_MHZ        50
`define IBS_HOLD_LONG_NS   300
`define IBS_HOLD_SHORT_NS  100
`define IBS_HOLD_LONG_CYC  ((`IBS_HOLD_LONG_NS * `IBS_CLK_MHZ + 999) / 1000)
`define IBS_HOLD_SHORT_CYC ((`IBS_HOLD_SHORT_NS * `IBS_CLK_MHZ + 999) / 1000)
`define IBS_SCL_HALF_NS    5000
`define IBS_SCL_HALF_CYC   ((`IBS_SCL_HALF_NS * `IBS_CLK_MHZ) / 1000)
`define IBS_SCL_QTR_CYC    (`IBS_SCL_HALF_CYC / 2)
`define IBS_TMR_W          9

// ----------------------------------------
// Framing
// ----------------------------------------
`define IBS_ADDR_W         7
`define IBS_BIT_LAST       4'h7
`define IBS_BIT_ACK        4'h8
`define IBS_BIT_PRE        4'hF

`endif

// ==== common/ibs_pkg.sv ====
package ibs_pkg;
  typedef logic [7:0] ibs_byte_t;
  typedef logic [8:0] ibs_tmr_t;
  typedef enum logic [4:0] {
    DS_IDLE   = 5'h01,
    DS_MSTART = 5'h02,
    DS_XFER   = 5'h04,
    DS_MSTOP  = 5'h08,
    DS_LOST   = 5'h10
  } ibs_dst_e;
  typedef enum logic [4:0] {
    HS_IDLE  = 5'h01,
    HS_START = 5'h02,
    HS_BIT   = 5'h04,
    HS_STOP  = 5'h08,
    HS_LOST  = 5'h10
  } ibs_hst_e;
endpackage

// ==== common/ibs_link_if.sv ====
`timescale 1ns/1ps
interface ibs_link_if;
  logic scl;
  logic sda;
  logic dev_scl_o;
  logic dev_scl_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;

  // Pull-up wired-AND of both open-drain ends.
  assign scl = (dev_scl_oe_n | dev_scl_o) & (host_scl_oe_n | host_scl_o);
  assign sda = (dev_sda_oe_n | dev_sda_o) & (host_sda_oe_n | host_sda_o);

  modport dev (input scl, input sda, output dev_scl_o, output dev_scl_oe_n, output dev_sda_o, output dev_sda_oe_n);
  modport host (input scl, input sda, output host_scl_o, output host_scl_oe_n, output host_sda_o,
                output host_sda_oe_n);
endinterface

// ==== verilog/ibs_buf2.sv ====
`timescale 1ns/1ps
module ibs_buf2 #(
  parameter int W = 8
) (
  input  wire logic         i_ref_clk,
  input  wire logic         i_rst,
  input  wire logic [W-1:0] i_data,
  input  wire logic         i_valid,
  output logic              o_ready,
  output logic [W-1:0]      o_data,
  output logic              o_valid,
  input  wire logic         i_ready
);
  logic [W-1:0] mem_r [2];
  logic         wp_r;
  logic         rp_r;
  logic [1:0]   cnt_r;
  logic         push;
  logic         pop;

  assign o_ready = (cnt_r != 2'h2);
  assign o_valid = (cnt_r != 2'h0);
  assign o_data  = mem_r[rp_r];
  assign push    = i_valid & o_ready;
  assign pop     = o_valid & i_ready;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      wp_r  <= 1'b0;
      rp_r  <= 1'b0;
      cnt_r <= 2'h0;
    end else begin
      if (push) wp_r <= ~wp_r;
      if (pop) rp_r <= ~rp_r;
      cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
    end
  end

  always_ff @(posedge i_ref_clk) begin
    if (push) mem_r[wp_r] <= i_data;
  end
endmodule // ibs_buf2

// ==== verilog/ibs_dev_end.sv ====
`timescale 1ns/1ps
`include "ibs_map.svh"

//Operation
// - Addressed slave may hold SCL low.
// - Master waits until released SCL reads high.
// - Track Start/Stop; start only on idle bus.
// - Transmitter losing SDA compare stops driving SDA.
// - Losing master releases SCL, awaits Stop.
// - Unchallenged transmitter continues its transfer unchanged.
// - Arbitration check continues through data bytes.
// - Bytes shift out most significant bit first.
// - Nine bits; sender releases SDA for ack.
// - SDA changes with SCL low; sample rising.
// - Start is SDA falling while SCL high.
// - Idle means not busy, both lines high.
// - Collision when SDA low while releasing it.
// - Start collision if SDA already low.
// - Hold select picks 300 ns hold.
// - Pins open-drain; output value forced zero.
// - Read request: slave sends bytes until Stop/Restart; the code stops sending and goes idle at the first master NACK.
// - Address equal to slave register matches.
// - Stop is SDA rising while SCL high.
// - Stop needs SCL low since the Start.
module ibs_dev_end import ibs_pkg::*; (
  input  wire logic            i_ref_clk,
  input  wire logic            i_rst,
  ibs_link_if.dev              lnk,
  input  wire logic            i_port_enable,
  input  wire logic [6:0]      i_slave_address_reg,
  input  wire logic            i_sda_hold_select,
  input  wire logic            i_mst_req,
  input  wire ibs_byte_t       i_tx_data,
  input  wire logic            i_tx_valid,
  output logic                 o_tx_ready,
  output ibs_byte_t            o_rx_data,
  output logic                 o_rx_valid,
  input  wire logic            i_rx_ready,
  output logic                 o_bus_busy,
  output logic                 o_collision
);
  ibs_dst_e   st_r;
  logic [1:0] scl_sy_r, sda_sy_r;
  logic       scl_d_r, sda_d_r, scl_s, sda_s;
  logic       start_det, stop_det, scl_rise, scl_fall;
  logic       busy_r, low_seen_r, bus_idle, xfer_free;
  logic       mst_r, tx_r, addr_ph_r, want_r, ack_n_r;
  logic       load_pend_r, push_pend_r, coll_r;
  logic [3:0] bit_cnt_r;
  ibs_byte_t  sh_r, txb_data;
  logic       txb_valid, txb_ready, rxb_valid, rxb_ready;
  logic       sda_drv_r, scl_hold_r, mst_low_r, tmr_done, stop_done;
  ibs_tmr_t   hold_r, tmr_r;

  // ----------------------------------------
  // Line sampling and bus state
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
    end else begin
      scl_sy_r <= {scl_sy_r[0], lnk.scl};
      sda_sy_r <= {sda_sy_r[0], lnk.sda};
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
    end
  end

  assign scl_s     = scl_sy_r[1];
  assign sda_s     = sda_sy_r[1];
  assign scl_rise  = scl_s & ~scl_d_r;
  assign scl_fall  = ~scl_s & scl_d_r;
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s & low_seen_r;
  assign bus_idle  = ~busy_r & scl_s & sda_s;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      busy_r     <= 1'b0;
      low_seen_r <= 1'b0;
    end else begin
      if (start_det) busy_r <= 1'b1;
      else if (stop_det) busy_r <= 1'b0;
      if (start_det) low_seen_r <= 1'b0;
      else if (!scl_s) low_seen_r <= 1'b1;
    end
  end

  // ----------------------------------------
  // Word buffers
  // ----------------------------------------
  // A stalled consumer only stretches SCL; no word is dropped.
  assign xfer_free = (st_r == DS_XFER) & i_port_enable & ~(start_det & ~mst_r) & ~stop_det;
  assign txb_ready = load_pend_r & xfer_free;
  assign rxb_valid = push_pend_r & xfer_free;

  ibs_buf2 #(.W(8)) u_txb (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_data    (i_tx_data),
    .i_valid   (i_tx_valid),
    .o_ready   (o_tx_ready),
    .o_data    (txb_data),
    .o_valid   (txb_valid),
    .i_ready   (txb_ready)
  );

  ibs_buf2 #(.W(8)) u_rxb (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_data    (sh_r),
    .i_valid   (rxb_valid),
    .o_ready   (rxb_ready),
    .o_data    (o_rx_data),
    .o_valid   (o_rx_valid),
    .i_ready   (i_rx_ready)
  );

  // ----------------------------------------
  // Transfer sequencing
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r        <= DS_IDLE;
      mst_r       <= 1'b0;
      tx_r        <= 1'b0;
      addr_ph_r   <= 1'b0;
      bit_cnt_r   <= 4'h0;
      sh_r        <= 8'h00;
      want_r      <= 1'b1;
      ack_n_r     <= 1'b1;
      load_pend_r <= 1'b0;
      push_pend_r <= 1'b0;
      coll_r      <= 1'b0;
    end else begin
      coll_r <= 1'b0;
      if (!i_port_enable) begin
        st_r        <= DS_IDLE;
        load_pend_r <= 1'b0;
        push_pend_r <= 1'b0;
      end else if (start_det && !mst_r && st_r != DS_MSTART) begin
        // A Restart resets the slave side from any state except DS_MSTART, but only while this end is not master (mst_r clear).
        st_r        <= DS_XFER;
        addr_ph_r   <= 1'b1;
        tx_r        <= 1'b0;
        want_r      <= 1'b1;
        bit_cnt_r   <= `IBS_BIT_PRE;
        load_pend_r <= 1'b0;
        push_pend_r <= 1'b0;
      end else begin
        case (st_r)
          DS_IDLE: begin
            want_r <= 1'b1;
            mst_r  <= 1'b0;
            if (i_mst_req && txb_valid && bus_idle) st_r <= DS_MSTART;
          end
          DS_MSTART: begin
            if (sda_drv_r && !sda_s) begin
              coll_r <= 1'b1;
              st_r   <= DS_LOST;
            end else if (tmr_done) begin
              st_r        <= DS_XFER;
              mst_r       <= 1'b1;
              tx_r        <= 1'b1;
              addr_ph_r   <= 1'b0;
              bit_cnt_r   <= `IBS_BIT_PRE;
              load_pend_r <= 1'b1;
            end
          end
          DS_XFER: begin
            if (stop_det) begin
              st_r        <= DS_IDLE;
              load_pend_r <= 1'b0;
              push_pend_r <= 1'b0;
            end else if (txb_ready && txb_valid) begin
              sh_r        <= txb_data;
              want_r      <= txb_data[7];
              load_pend_r <= 1'b0;
            end else if (rxb_valid && rxb_ready) begin
              push_pend_r <= 1'b0;
              want_r      <= 1'b0;
            end else if (scl_rise && bit_cnt_r < `IBS_BIT_ACK) begin
              if (tx_r && sda_drv_r && !sda_s) begin
                coll_r <= 1'b1;
                st_r   <= DS_LOST;
              end else if (!tx_r) begin
                sh_r <= {sh_r[6:0], sda_s};
              end
            end else if (scl_rise && bit_cnt_r == `IBS_BIT_ACK) begin
              ack_n_r <= sda_s;
            end else if (scl_fall) begin
              if (bit_cnt_r == `IBS_BIT_PRE) begin
                bit_cnt_r <= 4'h0;
              end else if (bit_cnt_r == `IBS_BIT_LAST) begin
                bit_cnt_r <= `IBS_BIT_ACK;
                if (addr_ph_r) begin
                  if (sh_r[7:1] == i_slave_address_reg) begin
                    want_r    <= 1'b0;
                    addr_ph_r <= 1'b0;
                    tx_r      <= sh_r[0];
                  end else begin
                    st_r <= DS_IDLE;
                  end
                end else if (tx_r) begin
                  want_r <= 1'b1;
                end else begin
                  push_pend_r <= 1'b1;
                end
              end else if (bit_cnt_r == `IBS_BIT_ACK) begin
                bit_cnt_r <= 4'h0;
                want_r    <= 1'b1;
                if (tx_r && ack_n_r) st_r <= mst_r ? DS_MSTOP : DS_IDLE;
                else if (mst_r && !(i_mst_req && txb_valid)) st_r <= DS_MSTOP;
                else if (tx_r) load_pend_r <= 1'b1;
              end else begin
                bit_cnt_r <= bit_cnt_r + 4'h1;
                if (tx_r) begin
                  sh_r   <= {sh_r[6:0], 1'b0};
                  want_r <= sh_r[6];
                end
              end
            end
          end
          DS_MSTOP: begin
            if (stop_done) st_r <= DS_IDLE;
          end
          DS_LOST: begin
            mst_r <= 1'b0;
            if (stop_det) st_r <= DS_IDLE;
          end
          default: st_r <= DS_IDLE;
        endcase
      end
    end
  end

  // ----------------------------------------
  // Master clock generation
  // ----------------------------------------
  assign tmr_done  = (tmr_r == '0);
  assign stop_done = (st_r == DS_MSTOP) & ~mst_low_r & scl_s & tmr_done;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      tmr_r     <= '0;
      mst_low_r <= 1'b0;
    end else if (st_r == DS_MSTART) begin
      if (!tmr_done) tmr_r <= tmr_r - ibs_tmr_t'(1);
      else begin
        mst_low_r <= 1'b1;
        tmr_r     <= ibs_tmr_t'(`IBS_SCL_HALF_CYC);
      end
    end else if ((st_r == DS_XFER && mst_r) || st_r == DS_MSTOP) begin
      if (mst_low_r) begin
        if (!tmr_done) tmr_r <= tmr_r - ibs_tmr_t'(1);
        else if (!load_pend_r && sda_drv_r == (want_r & (st_r == DS_XFER))) begin
          mst_low_r <= 1'b0;
          tmr_r     <= ibs_tmr_t'(`IBS_SCL_HALF_CYC);
        end
      end else if (scl_s) begin
        // High time counts only once the line really rose.
        if (!tmr_done) tmr_r <= tmr_r - ibs_tmr_t'(1);
        else if (st_r == DS_XFER) begin
          mst_low_r <= 1'b1;
          tmr_r     <= ibs_tmr_t'(`IBS_SCL_HALF_CYC);
        end
      end
    end else begin
      mst_low_r <= 1'b0;
      tmr_r     <= ibs_tmr_t'(`IBS_SCL_HALF_CYC);
    end
  end

  // ----------------------------------------
  // Pin drivers
  // ----------------------------------------
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      hold_r     <= '0;
      sda_drv_r  <= 1'b1;
      scl_hold_r <= 1'b0;
    end else begin
      if (scl_fall) hold_r <= i_sda_hold_select ? ibs_tmr_t'(`IBS_HOLD_LONG_CYC)
                                                : ibs_tmr_t'(`IBS_HOLD_SHORT_CYC);
      else if (hold_r != '0) hold_r <= hold_r - ibs_tmr_t'(1);
      scl_hold_r <= (st_r == DS_XFER) & ~mst_r
                    & (load_pend_r | push_pend_r | (scl_hold_r & (sda_drv_r != want_r)));
      if (st_r == DS_IDLE || st_r == DS_LOST) sda_drv_r <= 1'b1;
      else if (st_r == DS_MSTART) sda_drv_r <= 1'b0;
      else if (!scl_s && hold_r == '0 && !scl_fall) sda_drv_r <= want_r & (st_r == DS_XFER);
    end
  end

  // Output value is tied low; only the enables move.
  assign lnk.dev_sda_o    = 1'b0;
  assign lnk.dev_scl_o    = 1'b0;
  assign lnk.dev_sda_oe_n = sda_drv_r;
  assign lnk.dev_scl_oe_n = ~(scl_hold_r | mst_low_r);
  assign o_bus_busy       = busy_r;
  assign o_collision      = coll_r;
endmodule // ibs_dev_end

// ==== verilog/ibs_host_end.sv ====
`timescale 1ns/1ps
`include "ibs_map.svh"

module ibs_host_end import ibs_pkg::*; (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  ibs_link_if.host        lnk,
  input  wire logic       i_req,
  input  wire logic       i_rw,
  input  wire logic [6:0] i_addr,
  input  wire ibs_byte_t  i_wr_data,
  input  wire logic       i_wr_valid,
  output logic            o_wr_ready,
  output ibs_byte_t       o_rd_data,
  output logic            o_rd_valid,
  output logic            o_busy,
  output logic            o_arb_lost,
  output logic            o_nack,
  output logic            o_done
);
  ibs_hst_e   st_r;
  logic [1:0] scl_sy_r, sda_sy_r, ph_r;
  logic       scl_d_r, sda_d_r, scl_s, sda_s, start_det, stop_det;
  logic       busy_r, tick, step, rd_r, rw_r, addr_ph_r, ack_n_r;
  logic       sda_rel_r, scl_rel_r;
  logic [3:0] bit_r;
  ibs_byte_t  sh_r;
  ibs_tmr_t   div_r;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      scl_sy_r <= 2'h3;
      sda_sy_r <= 2'h3;
      scl_d_r  <= 1'b1;
      sda_d_r  <= 1'b1;
      busy_r   <= 1'b0;
      div_r    <= '0;
    end else begin
      scl_sy_r <= {scl_sy_r[0], lnk.scl};
      sda_sy_r <= {sda_sy_r[0], lnk.sda};
      scl_d_r  <= scl_s;
      sda_d_r  <= sda_s;
      if (start_det) busy_r <= 1'b1;
      else if (stop_det) busy_r <= 1'b0;
      div_r <= (div_r == '0) ? ibs_tmr_t'(`IBS_SCL_QTR_CYC - 1) : div_r - ibs_tmr_t'(1);
    end
  end

  assign scl_s     = scl_sy_r[1];
  assign sda_s     = sda_sy_r[1];
  assign start_det = scl_s & scl_d_r & sda_d_r & ~sda_s;
  assign stop_det  = scl_s & scl_d_r & ~sda_d_r & sda_s;
  assign tick      = (div_r == '0);
  assign step      = tick & ((ph_r != 2'h2) | scl_s);
  assign o_wr_ready = (st_r == HS_BIT) & step & (ph_r == 2'h3) & (bit_r == `IBS_BIT_ACK) & ~rd_r & ~ack_n_r
                      & ~(addr_ph_r & rw_r) & i_req;

  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      st_r       <= HS_IDLE;
      ph_r       <= 2'h0;
      bit_r      <= 4'h0;
      sh_r       <= 8'h00;
      rd_r       <= 1'b0;
      rw_r       <= 1'b0;
      addr_ph_r  <= 1'b0;
      ack_n_r    <= 1'b1;
      sda_rel_r  <= 1'b1;
      scl_rel_r  <= 1'b1;
      o_rd_data  <= 8'h00;
      o_rd_valid <= 1'b0;
      o_arb_lost <= 1'b0;
      o_nack     <= 1'b0;
      o_done     <= 1'b0;
    end else begin
      o_rd_valid <= 1'b0;
      o_arb_lost <= 1'b0;
      o_nack     <= 1'b0;
      o_done     <= 1'b0;
      case (st_r)
        HS_IDLE: begin
          sda_rel_r <= 1'b1;
          scl_rel_r <= 1'b1;
          ph_r      <= 2'h0;
          if (i_req && !busy_r && scl_s && sda_s && tick) st_r <= HS_START;
        end
        HS_START: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sda_rel_r <= 1'b0;
          if (ph_r == 2'h2) begin
            scl_rel_r <= 1'b0;
            sh_r      <= {i_addr, i_rw};
            rw_r      <= i_rw;
            rd_r      <= 1'b0;
            addr_ph_r <= 1'b1;
            bit_r     <= 4'h0;
            ph_r      <= 2'h0;
            st_r      <= HS_BIT;
          end
        end
        HS_BIT: if (step) begin
          ph_r <= ph_r + 2'h1;
          case (ph_r)
            2'h0: sda_rel_r <= (bit_r == `IBS_BIT_ACK) ? (~rd_r | ~i_req) : (rd_r | sh_r[7]);
            2'h1: scl_rel_r <= 1'b1;
            2'h2: begin
              if (bit_r == `IBS_BIT_ACK) ack_n_r <= sda_s;
              else if (!rd_r && sda_rel_r && !sda_s) begin
                o_arb_lost <= 1'b1;
                sda_rel_r  <= 1'b1;
                scl_rel_r  <= 1'b1;
                st_r       <= HS_LOST;
              end else begin
                sh_r <= {sh_r[6:0], sda_s};
              end
            end
            default: begin
              scl_rel_r <= 1'b0;
              if (bit_r != `IBS_BIT_ACK) begin
                bit_r <= bit_r + 4'h1;
                if (bit_r == `IBS_BIT_LAST && rd_r) begin
                  o_rd_data  <= sh_r;
                  o_rd_valid <= 1'b1;
                end
              end else begin
                bit_r     <= 4'h0;
                addr_ph_r <= 1'b0;
                if (rd_r) begin
                  if (sda_rel_r) st_r <= HS_STOP;
                end else if (ack_n_r) begin
                  o_nack <= 1'b1;
                  st_r   <= HS_STOP;
                end else if (addr_ph_r && rw_r) begin
                  rd_r <= 1'b1;
                end else if (i_req && i_wr_valid) begin
                  sh_r <= i_wr_data;
                end else begin
                  st_r <= HS_STOP;
                end
              end
            end
          endcase
        end
        HS_STOP: if (step) begin
          ph_r <= ph_r + 2'h1;
          if (ph_r == 2'h0) sda_rel_r <= 1'b0;
          if (ph_r == 2'h1) scl_rel_r <= 1'b1;
          if (ph_r == 2'h3) begin
            sda_rel_r <= 1'b1;
            o_done    <= 1'b1;
            st_r      <= HS_IDLE;
          end
        end
        HS_LOST: if (stop_det) st_r <= HS_IDLE;
        default: st_r <= HS_IDLE;
      endcase
    end
  end

  assign lnk.host_sda_o    = 1'b0;
  assign lnk.host_scl_o    = 1'b0;
  assign lnk.host_sda_oe_n = sda_rel_r;
  assign lnk.host_scl_oe_n = scl_rel_r;
  assign o_busy            = (st_r != HS_IDLE);
endmodule // ibs_host_end

// ==== verif/ibs_link_props.sv ====
`timescale 1ns/1ps
// ----------------------------------------
// Link checks
// ----------------------------------------
module ibs_link_props (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic scl,
  input wire logic sda,
  input wire logic dev_scl_o,
  input wire logic dev_scl_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic host_scl_o,
  input wire logic host_scl_oe_n,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n
);
  logic [3:0] pulse_r;
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // Counts SCL pulses since the last start, so the ninth one is the acknowledge slot.
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || ($fell(sda) && scl)) pulse_r <= 4'h0;
    else if ($fell(scl)) pulse_r <= (pulse_r == 4'h9) ? 4'h1 : pulse_r + 4'h1;
  end
  a_dev_out_zero: assert property (dev_sda_o == 1'b0 && dev_scl_o == 1'b0)
    else $error("device pin value not zero");
  a_host_out_zero: assert property (host_sda_o == 1'b0 && host_scl_o == 1'b0)
    else $error("host pin value not zero");
  a_dev_sda_hold: assert property ($fell(scl) |-> $stable(dev_sda_oe_n) [*6])
    else $error("device data changed too soon after clock fall");
  a_host_sda_hold: assert property ($fell(scl) |-> $stable(host_sda_oe_n) [*8])
    else $error("host data changed too soon after clock fall");
  a_host_start_idle: assert property ($fell(host_sda_oe_n) && scl |-> $past(sda, 2) && $past(scl, 2))
    else $error("host start on a busy bus");
  a_dev_start_idle: assert property ($fell(dev_sda_oe_n) && scl && dev_scl_oe_n |-> $past(sda, 2) && $past(scl, 2))
    else $error("device start on a busy bus");
  a_host_scl_wait: assert property ($fell(host_scl_oe_n) |-> $past(scl, 1) && $past(scl, 2))
    else $error("host pulled clock low before it was seen high");
  a_ack_slot_free: assert property (scl && pulse_r == 4'h9 |-> host_sda_oe_n || dev_sda_oe_n)
    else $error("sender kept data line in acknowledge slot");
  c_start: cover property ($fell(sda) && scl);
  c_stretch: cover property (!dev_scl_oe_n && host_scl_oe_n);
  c_ack: cover property (scl && pulse_r == 4'h9 && !sda);
endmodule // ibs_link_props

// ==== verif/i2c_bus_signalling_core_tb_top.sv ====
`timescale 1ns/1ps
module i2c_bus_signalling_core_tb_top import ibs_pkg::*;;
  logic        clk = 1'b0, rst = 1'b1, pen = 1'b1, hsel = 1'b0, mreq = 1'b0, txv = 1'b0, rxr = 1'b0;
  logic        req = 1'b0, rw = 1'b0, wrv = 1'b0, gnack, txr, rxv, bbusy, coll, wrr, rdv, hbusy, lost, nack, done;
  logic [6:0]  saddr = 7'h00, haddr = 7'h00;
  ibs_byte_t   txd = 8'h00, wrd = 8'h00, rxd, rdd, wq[$], rxq[$], rdq[$];
  logic [31:0] seed_r = 32'h0000_fd32, stall_r = 32'h0000_fd32;
  int          err_count = 0, check_count = 0, cycles = 0, n_coll = 0;
  ibs_link_if lnk ();
  ibs_dev_end ibs_dev_end_i (.i_ref_clk(clk), .i_rst(rst), .lnk(lnk.dev), .i_port_enable(pen),
    .i_slave_address_reg(saddr), .i_sda_hold_select(hsel), .i_mst_req(mreq), .i_tx_data(txd), .i_tx_valid(txv),
    .o_tx_ready(txr), .o_rx_data(rxd), .o_rx_valid(rxv), .i_rx_ready(rxr), .o_bus_busy(bbusy), .o_collision(coll));
  ibs_host_end ibs_host_end_i (.i_ref_clk(clk), .i_rst(rst), .lnk(lnk.host), .i_req(req), .i_rw(rw), .i_addr(haddr),
    .i_wr_data(wrd), .i_wr_valid(wrv), .o_wr_ready(wrr), .o_rd_data(rdd), .o_rd_valid(rdv), .o_busy(hbusy),
    .o_arb_lost(lost), .o_nack(nack), .o_done(done));
  ibs_link_props ibs_link_props_i (.i_ref_clk(clk), .i_rst(rst), .scl(lnk.scl), .sda(lnk.sda),
    .dev_scl_o(lnk.dev_scl_o), .dev_scl_oe_n(lnk.dev_scl_oe_n), .dev_sda_o(lnk.dev_sda_o),
    .dev_sda_oe_n(lnk.dev_sda_oe_n), .host_scl_o(lnk.host_scl_o), .host_scl_oe_n(lnk.host_scl_oe_n),
    .host_sda_o(lnk.host_sda_o), .host_sda_oe_n(lnk.host_sda_oe_n));
  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr(input logic [31:0] v);
    return {v[30:0], v[31] ^ v[21] ^ v[1] ^ v[0]};
  endfunction
  function automatic ibs_byte_t addr_byte(input logic [6:0] a, input logic r);
    return {a, r};
  endfunction
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("checks %0d mismatches %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic rnd8(output ibs_byte_t v);
    seed_r = lfsr(seed_r);
    v = seed_r[7:0];
  endtask
  task automatic dev_push(input ibs_byte_t b);
    int k;
    txd <= b;
    txv <= 1'b1;
    for (k = 0; k < 100; k++) begin
      @(posedge clk);
      if (txr === 1'b1) break;
    end
    check("tx taken", txr, 1'b1);
  endtask
  task automatic host_xfer(input logic r, input logic [6:0] a, input int nrd);
    int k;
    int wi;
    wi = 0;
    gnack = 1'b0;
    rdq.delete();
    req <= 1'b1;
    rw <= r;
    haddr <= a;
    wrd <= wq[0];
    wrv <= !r;
    for (k = 0; k < 30000 && done !== 1'b1; k++) begin
      @(posedge clk);
      if (nack === 1'b1) gnack = 1'b1;
      if (rdv === 1'b1) rdq.push_back(rdd);
      if (wrr === 1'b1 && wrv === 1'b1) begin
        wi++;
        if (wi < wq.size()) wrd <= wq[wi];
        else wrv <= 1'b0;
      end
      if (r ? (rdq.size() >= nrd) : (wi >= wq.size())) req <= 1'b0;
    end
    check("host done", done, 1'b1);
    @(posedge clk);
    req <= 1'b0;
    wrv <= 1'b0;
    @(posedge clk);
  endtask
  always #10 clk = ~clk;
  // The receiver stalls about a quarter of the time; the two-word buffer absorbs it, so the slave never has to stretch the clock.
  always @(posedge clk) begin
    cycles <= cycles + 1;
    stall_r <= lfsr(stall_r);
    rxr <= stall_r[0] | stall_r[5];
    if (rxv === 1'b1 && rxr === 1'b1) rxq.push_back(rxd);
    if (coll === 1'b1 || lost === 1'b1) n_coll <= n_coll + 1;
    if (cycles == 90000) begin
      err_count = err_count + 1;
      conclude();
    end
  end
  initial begin
    ibs_byte_t b;
    int k;
    int n;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    rnd8(b);
    saddr <= b[6:0];
    @(posedge clk);
    rnd8(b);
    wq = '{b, 8'h80, 8'h01};
    host_xfer(1'b0, saddr, 0);
    check("write acked", gnack, 1'b0);
    repeat (20) @(posedge clk);
    for (k = 0; k < 3; k++) check("rx byte", rxq[rxq.size() - 3 + k], wq[k]);
    check("bus idle", bbusy, 1'b0);
    hsel <= 1'b1;
    rnd8(b);
    wq = '{b, 8'hc3};
    dev_push(wq[0]);
    dev_push(wq[1]);
    txv <= 1'b0;
    host_xfer(1'b1, saddr, 2);
    check("read count", rdq.size(), 2);
    for (k = 0; k < 2; k++) check("rd byte", rdq[k], wq[k]);
    n = rxq.size();
    wq = '{8'h5a};
    host_xfer(1'b0, saddr ^ 7'h01, 0);
    check("mismatch nacked", gnack, 1'b1);
    check("no rx word", rxq.size(), n);
    mreq <= 1'b1;
    dev_push(addr_byte(saddr ^ 7'h02, 1'b0));
    txv <= 1'b0;
    for (k = 0; k < 2000 && bbusy !== 1'b1; k++) @(posedge clk);
    check("master start busy", bbusy, 1'b1);
    mreq <= 1'b0;
    wq = '{8'h3c};
    host_xfer(1'b0, saddr ^ 7'h04, 0);
    check("late host nacked", gnack, 1'b1);
    check("host idle", hbusy, 1'b0);
    check("no collision", n_coll, 0);
    pen <= 1'b0;
    repeat (3) @(posedge clk);
    check("disabled release", {lnk.dev_scl_oe_n, lnk.dev_sda_oe_n}, 2'b11);
    conclude();
  end
endmodule // i2c_bus_signalling_core_tb_top
